// File: flash_gov_regs.vh
/*
  Register map, field positions, reset values and timing constants of the
  flash LED supply-drop governor. Assumes a 100 MHz system clock.
*/
`ifndef FLASH_GOV_REGS_VH
`define FLASH_GOV_REGS_VH

// Byte addresses on the register port
`define ADDR_CTRL        8'h00
`define ADDR_CUR0        8'h04
`define ADDR_CUR1        8'h08
`define ADDR_THRESH      8'h0C
`define ADDR_DELAY       8'h10
`define ADDR_STATUS      8'h14
`define ADDR_CLEAR       8'h18
`define ADDR_INT_EN      8'h1C
`define ADDR_STATE       8'h20

// Field positions
`define CTRL_GOV_EN_BIT  2
`define THR_HYS_LSB      4
`define DLY_RISE_LSB     8
`define ST_SHORT_LSB     2
`define STATE_CODE1_LSB  8
`define STATE_EVENT_BIT  16

// Reset values
`define CTRL_RST         3'h4
`define CUR_RST          6'h10
`define THRESH_RST       7'h18
`define DELAY_RST        16'h0101
`define INT_EN_RST       4'h0

// Timing
`define CLK_MHZ          100
`define TICK_US          1
`define TICK_CYCLES      (`TICK_US * `CLK_MHZ)
`define OPEN_TIME_US     8000
`define SHORT_TIME_US    1000
`define OPEN_CYCLES      (`OPEN_TIME_US * `CLK_MHZ)
`define SHORT_CYCLES     (`SHORT_TIME_US * `CLK_MHZ)

`endif

// File: delay_timer.v
/*
  Resample delay counter: loads a count and steps it down on each tick.
  Assumes tick is a one-cycle enable pulse in the clk domain.
*/
`default_nettype none

module delay_timer #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         tick,
  input  wire         load,
  input  wire [W-1:0] load_val,
  output wire         done
);

  reg [W-1:0] count;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      count <= {W{1'b0}};
    else if (load)
      count <= load_val;
    else if (tick && count != {W{1'b0}})
      count <= count - 1'b1;
  end

  assign done = (count == {W{1'b0}}) && !load;

endmodule // delay_timer

`default_nettype wire

// File: fault_persist.v
/*
  Persistence filter: held goes high once cond has stayed high for LIMIT
  consecutive cycles, and falls as soon as cond drops.
  Assumes cond is synchronous to clk.
*/
`default_nettype none

module fault_persist #(
  parameter         W     = 20,
  parameter [W-1:0] LIMIT = 20'd1
) (
  input  wire clk,
  input  wire rst_b,
  input  wire cond,
  output wire held
);

  reg [W-1:0] count;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      count <= {W{1'b0}};
    else if (!cond)
      count <= {W{1'b0}};
    else if (count != LIMIT)
      count <= count + 1'b1;
  end

  assign held = (count == LIMIT);

endmodule // fault_persist

`default_nettype wire

// File: flash_led_governor.v
/*
  Dual-channel flash/torch LED current governor: supply-drop stepping,
  open/short LED monitors, register port and interrupt.
  Assumes comparator and event inputs are synchronous to clk and that the
  analog side applies led_current_code and regulator_enable.
*/
// Implementation choices: the address-and-strobe port and the address map.
// What this block does
// RULE1 - Current decisions use the system supply rail comparator, never the battery voltage.
// RULE2 - During a flash or torch event a supply below the drop threshold is detected.
// RULE3 - A supply below threshold lowers the LED current by exactly one step.
// RULE4 - After each adjustment a separate falling or rising delay runs before resampling.
// RULE5 - A supply still below threshold after the delay lowers the current one more step.
// RULE6 - A supply above threshold plus hysteresis raises the current one step if below setting.
// RULE7 - A hysteresis setting of 000 disables all current increases.
// RULE8 - The sample, delay and adjust loop runs for the whole event.
// RULE9 - The LED node held near the bypass rail for 8 ms is an open fault.
// RULE10 - The LED node held below 1.0 V for 1 ms is a short fault.
// RULE11 - Open and short monitors run only while the regulator is on and an event is active.
// RULE12 - A fault disables its regulator and latches a status bit.
// RULE13 - The active-low interrupt falls only for faults whose enable bit is set.
// RULE14 - A step is one code; codes stop at zero and never exceed the setting.
// RULE15 - Fault bits stay set until cleared and the regulator stays off until re-enabled.
`include "flash_gov_regs.vh"
`default_nettype none

module flash_led_governor #(
  parameter CODE_W       = 6,
  parameter DLY_W        = 8,
  parameter FLT_W        = 20,
  parameter OPEN_CYCLES  = `OPEN_CYCLES,
  parameter SHORT_CYCLES = `SHORT_CYCLES
) (
  input  wire                  clk,
  input  wire                  rst_b,
  input  wire [7:0]            addr,
  input  wire [31:0]           wdata,
  input  wire                  wr,
  input  wire                  rd,
  output reg  [31:0]           rdata,
  input  wire                  event_active,
  input  wire                  supply_below_threshold,
  input  wire                  supply_above_hysteresis,
  input  wire [1:0]            led_open_cmp,
  input  wire [1:0]            led_short_cmp,
  output wire [3:0]            supply_drop_threshold,
  output wire [2:0]            supply_recover_hysteresis,
  output wire [2*CODE_W-1:0]   led_current_code,
  output wire [1:0]            regulator_enable,
  output reg                   int_b
);

  localparam S_IDLE   = 2'd0;
  localparam S_SAMPLE = 2'd1;
  localparam S_WAIT   = 2'd2;
  localparam [31:0] TICK_FULL  = `TICK_CYCLES - 1;
  localparam [6:0]  TICK_LAST  = TICK_FULL[6:0];
  localparam [2:0]  CTRL_RST_V = `CTRL_RST;

  wire [2:0]          ctrl;
  reg                 gov_on;
  reg  [CODE_W-1:0]   cur0;
  reg  [CODE_W-1:0]   cur1;
  reg  [6:0]          thresh;
  reg  [15:0]         delay;
  reg  [3:0]          status;
  reg  [3:0]          int_en;
  reg  [1:0]          state;
  reg  [1:0]          next_state;
  reg  [6:0]          tick_cnt;
  reg                 tick;
  reg  [31:0]         next_rdata;
  wire [2*CODE_W-1:0] user_code;
  wire [1:0]          below_user;
  wire [1:0]          open_hit;
  wire [1:0]          short_hit;
  wire [3:0]          fault_set;
  wire [3:0]          fault_clr;
  wire                gov_en;
  wire                hys_zero;
  wire                step_down;
  wire                step_up;
  wire                timer_load;
  wire [DLY_W-1:0]    timer_val;
  wire                timer_done;
  wire                wr_ctrl;
  wire                irq_pending;

  assign supply_drop_threshold     = thresh[3:0];
  assign supply_recover_hysteresis = thresh[6:4];
  assign regulator_enable          = ctrl[1:0];
  assign user_code                 = {cur1, cur0};
  assign gov_en                    = ctrl[`CTRL_GOV_EN_BIT];
  assign hys_zero                  = (supply_recover_hysteresis == 3'h0);
  assign wr_ctrl                   = wr && (addr == `ADDR_CTRL);
  assign ctrl[`CTRL_GOV_EN_BIT]    = gov_on;

  // Microsecond tick for the resample delays
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_cnt <= 7'h00;
      tick     <= 1'b0;
    end
    else if (tick_cnt == TICK_LAST)
    begin
      tick_cnt <= 7'h00;
      tick     <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 7'h01;
      tick     <= 1'b0;
    end
  end

  // Governor decisions, taken from the system rail comparators
  // Both channels step together off the one shared rail comparator
  assign step_down = gov_en && (state == S_SAMPLE)
                     && supply_below_threshold; // RULE1 RULE2 RULE3 RULE5
  assign step_up   = gov_en && (state == S_SAMPLE) && !supply_below_threshold
                     && supply_above_hysteresis && !hys_zero
                     && (|below_user); // RULE1 RULE6 RULE7

  // Falling delay after a step down, rising delay after a step up
  assign timer_load = step_down || step_up;
  assign timer_val  = step_down ? delay[DLY_W-1:0]
                                : delay[`DLY_RISE_LSB +: DLY_W]; // RULE4

  delay_timer #(
    .W        (DLY_W)
  ) u_delay (
    .clk      (clk),
    .rst_b    (rst_b),
    .tick     (tick),
    .load     (timer_load),
    .load_val (timer_val),
    .done     (timer_done)
  );

  always @*
  begin
    next_state = state;
    case (state)
      S_IDLE:
      begin
        if (event_active)
          next_state = S_SAMPLE;
      end
      S_SAMPLE:
      begin
        if (!event_active)
          next_state = S_IDLE;
        else if (timer_load)
          next_state = S_WAIT; // RULE4
      end
      S_WAIT:
      begin
        if (!event_active)
          next_state = S_IDLE;
        else if (timer_done)
          next_state = S_SAMPLE; // RULE8
      end
      default:
        next_state = S_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  // Per-channel current code and fault monitors
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_ch
      wire [CODE_W-1:0] user;
      wire              reg_on;
      wire              open_cond;
      wire              short_cond;
      wire              fault_hit;
      reg  [CODE_W-1:0] code;
      reg  [CODE_W-1:0] next_code;
      reg               en;

      assign user          = user_code[i*CODE_W +: CODE_W];
      assign below_user[i] = (code < user);
      assign reg_on        = en && event_active;
      assign open_cond     = led_open_cmp[i] && reg_on; // RULE9 RULE11
      assign short_cond    = led_short_cmp[i] && reg_on; // RULE10 RULE11
      assign fault_hit     = open_hit[i] || short_hit[i];
      assign ctrl[i]       = en;
      assign led_current_code[i*CODE_W +: CODE_W] = code;

      // Outside an event the code tracks the setting; a lowered setting clamps it
      always @*
      begin
        next_code = code;
        if (!event_active || code > user)
          next_code = user; // RULE14
        else if (step_down && code != {CODE_W{1'b0}})
          next_code = code - 1'b1; // RULE3 RULE14
        else if (step_up && code < user)
          next_code = code + 1'b1; // RULE6 RULE14
      end

      always @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          code <= `CUR_RST;
        else
          code <= next_code;
      end

      // Persistence filters restart on any gap in the comparator
      fault_persist #(
        .W     (FLT_W),
        .LIMIT (OPEN_CYCLES[FLT_W-1:0])
      ) u_open (
        .clk   (clk),
        .rst_b (rst_b),
        .cond  (open_cond),
        .held  (open_hit[i])
      );

      fault_persist #(
        .W     (FLT_W),
        .LIMIT (SHORT_CYCLES[FLT_W-1:0])
      ) u_short (
        .clk   (clk),
        .rst_b (rst_b),
        .cond  (short_cond),
        .held  (short_hit[i])
      );

      // A fault beats a same-cycle re-enable
      always @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          en <= CTRL_RST_V[i];
        else if (fault_hit)
          en <= 1'b0; // RULE12 RULE15
        else if (wr_ctrl)
          en <= wdata[i];
      end
    end
  endgenerate

  assign fault_set = {short_hit, open_hit};
  assign fault_clr = (wr && addr == `ADDR_CLEAR) ? wdata[3:0] : 4'h0;

  // Status: a fault set in the clearing cycle is kept
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      status <= 4'h0;
    else
      status <= (status & ~fault_clr) | fault_set; // RULE12 RULE15
  end

  // Register writes
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gov_on  <= CTRL_RST_V[`CTRL_GOV_EN_BIT];
      cur0    <= `CUR_RST;
      cur1    <= `CUR_RST;
      thresh  <= `THRESH_RST;
      delay   <= `DELAY_RST;
      int_en  <= `INT_EN_RST;
    end
    else
    begin
      if (wr_ctrl)
        gov_on <= wdata[`CTRL_GOV_EN_BIT];
      if (wr)
      begin
        case (addr)
          `ADDR_CUR0:   cur0   <= wdata[CODE_W-1:0];
          `ADDR_CUR1:   cur1   <= wdata[CODE_W-1:0];
          `ADDR_THRESH: thresh <= wdata[6:0];
          `ADDR_DELAY:  delay  <= wdata[15:0];
          `ADDR_INT_EN: int_en <= wdata[3:0];
          default:      ;
        endcase
      end
    end
  end

  // Interrupt pin, registered so it never glitches on a status update
  assign irq_pending = |(status & int_en);

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      int_b <= 1'b1;
    else
      int_b <= !irq_pending; // RULE13
  end

  // Read data, valid only in the cycle after the read strobe
  // Zero outside that cycle so a stale word never lingers on the bus
  always @*
  begin
    next_rdata = 32'h0000_0000;
    case (addr)
      `ADDR_CTRL:   next_rdata[2:0]        = ctrl;
      `ADDR_CUR0:   next_rdata[CODE_W-1:0] = cur0;
      `ADDR_CUR1:   next_rdata[CODE_W-1:0] = cur1;
      `ADDR_THRESH: next_rdata[6:0]        = thresh;
      `ADDR_DELAY:  next_rdata[15:0]       = delay;
      `ADDR_STATUS: next_rdata[3:0]        = status;
      `ADDR_INT_EN: next_rdata[3:0]        = int_en;
      `ADDR_STATE:
      begin
        next_rdata[CODE_W-1:0] = led_current_code[CODE_W-1:0];
        next_rdata[`STATE_CODE1_LSB +: CODE_W] =
          led_current_code[CODE_W +: CODE_W];
        next_rdata[`STATE_EVENT_BIT] = event_active;
      end
      default:      next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata <= 32'h0000_0000;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= 32'h0000_0000;
  end

endmodule // flash_led_governor

`default_nettype wire

// File: gov_chk.sv
/* Concurrent checks on the governor ports.
   Assumes a bind to flash_led_governor from the bench top. */
`include "flash_gov_regs.vh"
`default_nettype none
module gov_chk #(
  parameter CODE_W = 6
) (
  input wire logic                clk,
  input wire logic                rst_b,
  input wire logic [7:0]          addr,
  input wire logic                wr,
  input wire logic                event_active,
  input wire logic                supply_below_threshold,
  input wire logic                supply_above_hysteresis,
  input wire logic [1:0]          led_open_cmp,
  input wire logic [1:0]          led_short_cmp,
  input wire logic [2:0]          supply_recover_hysteresis,
  input wire logic [2*CODE_W-1:0] led_current_code,
  input wire logic [1:0]          regulator_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [CODE_W-1:0] c0;
  assign c0 = led_current_code[CODE_W-1:0];
  a_step_one: assert property (
    event_active && $past(event_active) && !$past(wr) && !$past(wr, 2)
    |-> c0 == $past(c0) || c0 + 1 == $past(c0) || c0 == $past(c0) + 1)
    else $error("code moved by more than one");
  a_hys_zero: assert property (
    event_active && supply_recover_hysteresis == 3'h0
    && $past(supply_recover_hysteresis) == 3'h0 |-> c0 <= $past(c0))
    else $error("code rose with zero hysteresis");
  a_fall_cause: assert property (
    event_active && !$past(wr) && !$past(wr, 2) && c0 < $past(c0)
    |-> $past(supply_below_threshold) || $past(supply_below_threshold, 2)
    || $past(supply_below_threshold, 3))
    else $error("code fell without low supply");
  a_rise_cause: assert property (
    event_active && $past(event_active) && c0 > $past(c0)
    |-> $past(supply_above_hysteresis) || $past(supply_above_hysteresis, 2)
    || $past(supply_above_hysteresis, 3))
    else $error("code rose without recovery");
  a_hys_hold: assert property (
    !$past(wr) |-> $stable(supply_recover_hysteresis))
    else $error("hysteresis changed without write");
  a_en_write: assert property (
    (regulator_enable & ~$past(regulator_enable)) != 2'h0
    |-> $past(wr) && $past(addr) == `ADDR_CTRL)
    else $error("regulator enabled without write");
  a_en_fault: assert property (
    (~regulator_enable & $past(regulator_enable)) != 2'h0 |-> $past(wr)
    || $past(led_open_cmp) != 2'h0 || $past(led_short_cmp) != 2'h0)
    else $error("regulator dropped without cause");
  a_idle_hold: assert property (
    !event_active && !$past(event_active) && !$past(wr) && !$past(wr, 2)
    |-> $stable(led_current_code))
    else $error("code moved outside event");
endmodule // gov_chk
`default_nettype wire

// File: supply_model.sv
/* System rail comparator model facing the governor.
   Assumes limit is one above the highest code the battery carries. */
`default_nettype none
module supply_model (
  input  wire logic [5:0] code,
  input  wire logic [6:0] limit,
  output logic            below,
  output logic            above
);
  always_comb
  begin
    below = {1'b0, code} >= limit;
    above = {1'b0, code} + 7'h01 < limit;
  end
endmodule // supply_model
`default_nettype wire

// File: tb.sv
/* Bench top: register map, supply-drop stepping and LED fault tests.
   Assumes the governor, supply_model and gov_chk are compiled first. */
`include "flash_gov_regs.vh"
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, wr, rd, event_active, below, above, int_b;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [1:0]  led_open_cmp, led_short_cmp, regulator_enable;
  logic [11:0] led_current_code;
  logic [3:0]  thr;
  logic [2:0]  hys;
  logic [6:0]  limit, lim;
  logic [5:0]  user, u1;
  int          failures, total_checks, gap;
  flash_led_governor #(.OPEN_CYCLES(40), .SHORT_CYCLES(10)) DUT (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .event_active(event_active), .supply_below_threshold(below),
    .supply_above_hysteresis(above), .led_open_cmp(led_open_cmp),
    .led_short_cmp(led_short_cmp), .supply_drop_threshold(thr),
    .supply_recover_hysteresis(hys), .led_current_code(led_current_code),
    .regulator_enable(regulator_enable), .int_b(int_b));
  supply_model SUP (.code(led_current_code[5:0]), .limit(limit), .below(below),
    .above(above));
  function automatic logic [5:0] settle(input logic [5:0] u, input logic [6:0] l);
    if (l == 7'h00)
      return 6'h00;
    return ({1'b0, u} < l) ? u : 6'(l - 7'h01);
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
    @(posedge clk);
    #1;
    `CHK("rdata_idle", 32'h0, rdata)
  endtask
  // Moves the supply limit, waits for the code, then checks it holds
  task automatic run_to(input logic [6:0] l, input logic [5:0] e);
    @(posedge clk);
    limit <= l;
    for (int i = 0; i < 20000 && led_current_code[5:0] !== e; i++) @(posedge clk) #1;
    repeat (700) @(posedge clk);
    #1;
    `CHK("code0", e, led_current_code[5:0])
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  initial
  begin
    rst_b = 1'b0;
    {wr, rd, event_active, addr, wdata} = '0;
    {led_open_cmp, led_short_cmp} = 4'h0;
    limit = 7'h40;
    void'($urandom(32'hb3a5));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(`ADDR_CTRL, 32'(`CTRL_RST));
    rd_chk(`ADDR_CUR1, 32'(`CUR_RST));
    rd_chk(`ADDR_THRESH, 32'(`THRESH_RST));
    rd_chk(`ADDR_DELAY, 32'(`DELAY_RST));
    rd_chk(`ADDR_INT_EN, 32'(`INT_EN_RST));
    wr_reg(`ADDR_STATUS, 32'hF);
    rd_chk(`ADDR_STATUS, 32'h0);
    rd_chk(8'h24, 32'h0);
    $display("test registers done");
    wr_reg(`ADDR_DELAY, 32'h0102);
    wr_reg(`ADDR_CTRL, 32'h7);
    user = `CUR_RST;
    @(posedge clk);
    event_active <= 1'b1;
    limit <= 7'h00;
    for (int i = 0; i < 1000 && led_current_code[5:0] === user; i++) @(posedge clk) #1;
    for (gap = 0; gap < 1000 && led_current_code[5:0] === user - 6'h01; gap++)
      @(posedge clk) #1;
    `CHK("gap", 1'b1, gap >= 100 && gap <= 205)
    run_to(7'h00, 6'h00);
    wr_reg(`ADDR_THRESH, 32'h08);
    #1;
    `CHK("thr", 4'h8, thr)
    `CHK("hys", 3'h0, hys)
    run_to(7'h40, 6'h00);
    wr_reg(`ADDR_THRESH, 32'h18);
    run_to(7'h40, user);
    $display("test corners done");
    wr_reg(`ADDR_DELAY, 32'h0);
    for (int r = 0; r < 4; r++)
    begin
      @(posedge clk);
      event_active <= 1'b0;
      user = 6'($urandom);
      wr_reg(`ADDR_CUR0, {26'h0, user});
      u1 = 6'($urandom_range(63));
      wr_reg(`ADDR_CUR1, {26'h0, u1});
      @(posedge clk);
      event_active <= 1'b1;
      lim = 7'($urandom_range(64));
      run_to(lim, settle(user, lim));
      run_to(7'h40, user);
    end
    @(posedge clk);
    event_active <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("code0", user, led_current_code[5:0])
    `CHK("code1", u1, led_current_code[11:6])
    rd_chk(`ADDR_STATE, {18'h0, u1, 2'h0, user});
    $display("test random done");
    wr_reg(`ADDR_INT_EN, 32'h1);
    event_active <= 1'b1;
    led_short_cmp <= 2'b10;
    repeat (9) @(posedge clk);
    led_short_cmp <= 2'b00;
    rd_chk(`ADDR_STATUS, 32'h0);
    @(posedge clk);
    led_short_cmp <= 2'b10;
    led_open_cmp <= 2'b01;
    repeat (60) @(posedge clk);
    `CHK("reg_en", 2'b00, regulator_enable)
    `CHK("int_b", 1'b0, int_b)
    rd_chk(`ADDR_STATUS, 32'h9);
    @(posedge clk);
    {led_open_cmp, led_short_cmp, event_active} <= 5'h0;
    wr_reg(`ADDR_CLEAR, 32'h1);
    repeat (3) @(posedge clk);
    `CHK("int_b", 1'b1, int_b)
    rd_chk(`ADDR_STATUS, 32'h8);
    `CHK("reg_en", 2'b00, regulator_enable)
    wr_reg(`ADDR_INT_EN, 32'h8);
    repeat (3) @(posedge clk);
    `CHK("int_b", 1'b0, int_b)
    wr_reg(`ADDR_CTRL, 32'h7);
    repeat (2) @(posedge clk);
    `CHK("reg_en", 2'b11, regulator_enable)
    $display("test faults done");
    report_and_stop();
  end
endmodule // tb
bind flash_led_governor gov_chk #(.CODE_W(CODE_W)) chk (.clk(clk), .rst_b(rst_b),
  .addr(addr), .wr(wr), .event_active(event_active),
  .supply_below_threshold(supply_below_threshold),
  .supply_above_hysteresis(supply_above_hysteresis), .led_open_cmp(led_open_cmp),
  .led_short_cmp(led_short_cmp), .supply_recover_hysteresis(supply_recover_hysteresis),
  .led_current_code(led_current_code), .regulator_enable(regulator_enable));
`default_nettype wire
